// *** hw/rtcp_map.svh ***
`ifndef RTCP_MAP_SVH
`define RTCP_MAP_SVH
// Function
// R1 - Write-protect high blocks every memory write; low lets all addresses write.
// R2 - Write-protect input reads low when left undriven.
// R3 - Shared output role comes from the select bit of control register 0Eh.
// R4 - Select bit 0: shared output carries square wave at rate-bit frequency.
// R5 - Select bit 1: shared output pulls low on any enabled alarm match.
// R6 - Power-up sets select bit to 1 with both alarms disabled.
// R7 - Recovery delay only with oscillator enabled and running; else release at once.
// R8 - Reset pin level never gates serial, timekeeping or memory logic.
// R9 - Set stop flag after oscillator stopped for the detection interval.
// R10 - Fixed clock output toggles on main or backup supply when enabled.
// R11 - Reset output low while supply fails; release after reset active time.
// R12 - Pushbutton low on reset pin, debounced, starts a reset pulse.
// R13 - Open-drain outputs are drive-low enables; released means pulled up.

// Register offsets
`define RTCP_CTRL_OFS 8'h0E
`define RTCP_STAT_OFS 8'h0F
// Control register fields and reset value
`define RTCP_B_A1IE 0
`define RTCP_B_A2IE 1
`define RTCP_B_SEL 2
`define RTCP_B_RSLO 3
`define RTCP_B_RSHI 4
`define RTCP_B_ODIS 7
`define RTCP_CTRL_RST 8'h1C
// Status register fields and reset value
`define RTCP_B_A1F 0
`define RTCP_B_A2F 1
`define RTCP_B_FEN 3
`define RTCP_B_OSF 7
`define RTCP_FLAG_RST 3'h4
`define RTCP_FEN_RST 1'b1
// Timing
`define RTCP_CLK_HZ 25000000
`define RTCP_CLK_KHZ 25000
`define RTCP_T_RST_MS 250
`define RTCP_T_DB_MS 250
`define RTCP_T_OSF_MS 100
`define RTCP_T_REC_MS 300
`define RTCP_FIX_HZ 32768
`define RTCP_WAVE_F0_HZ 1
`define RTCP_WAVE_F1_HZ 1024
`define RTCP_WAVE_F2_HZ 4096
`define RTCP_WAVE_F3_HZ 8192
`endif

// *** hw/rtcp_pkg.sv ***
package rtcp_pkg;
    // Reset pin sequencing states
    typedef enum logic [1:0] {
        RS_DRIVE,
        RS_HOLD,
        RS_RELEASED,
        RS_DEBOUNCE
    } rtcp_rst_state_t;
endpackage

// *** hw/rtcp_top.sv ***
`timescale 1ns/10ps
`include "rtcp_map.svh"
module rtcp_top
    import rtcp_pkg::*;
#(
    parameter int unsigned CW = 24,
    parameter int unsigned RST_CYC = `RTCP_CLK_KHZ * `RTCP_T_RST_MS,
    parameter int unsigned DB_CYC = `RTCP_CLK_KHZ * `RTCP_T_DB_MS,
    parameter int unsigned OSF_CYC = `RTCP_CLK_KHZ * `RTCP_T_OSF_MS,
    parameter int unsigned HALF0 = `RTCP_CLK_HZ / (2 * `RTCP_WAVE_F0_HZ),
    parameter int unsigned HALF1 = `RTCP_CLK_HZ / (2 * `RTCP_WAVE_F1_HZ),
    parameter int unsigned HALF2 = `RTCP_CLK_HZ / (2 * `RTCP_WAVE_F2_HZ),
    parameter int unsigned HALF3 = `RTCP_CLK_HZ / (2 * `RTCP_WAVE_F3_HZ),
    parameter int unsigned FIX_HALF = `RTCP_CLK_HZ / (2 * `RTCP_FIX_HZ)
)
(
    // Core clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Serial interface side
    input wire logic link_clk,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic mem_wr_req,
    output logic mem_wr_en,
    // Timekeeping and analog status
    input wire logic alarm1_match,
    input wire logic alarm2_match,
    input wire logic osc_run,
    input wire logic vcc_ok,
    // Write-protect pin
    input wire logic wp_in,
    // Reset pin, open drain, two-way
    input wire logic rst_in,
    output logic rst_out,
    output logic rst_oe_n,
    // Shared interrupt or square wave pin
    output logic irq_or_wave_out,
    output logic irq_or_wave_oe_n,
    // Fixed clock pin
    output logic fixed_clock_out,
    output logic fixed_clock_oe_n
);

    // Link-domain registers and decode
    logic [1:0] lrst_sync_ff;
    logic wp_s1_ff, wp_s2_ff, fen_ff, mem_wr_en_ff;
    logic [7:0] ctrl_ff, rdata_ff, stat_view, nxt_rdata;
    logic [2:0] clr_tgl_ff, flg_l1_ff, flg_l2_ff, clr_req, nxt_clr_tgl;
    logic lrst, wr_ctrl, wr_stat, nxt_mem_wr_en;
    // Sticky event flags, owned by the core domain
    logic [2:0] flags_ff;

    // Reset brought into the link domain
    always_ff @(posedge link_clk)
    begin
        lrst_sync_ff <= {lrst_sync_ff[0], reset};
    end

    // Write decode and read selection
    assign lrst = lrst_sync_ff[1];
    assign wr_ctrl = reg_wr && (reg_addr == `RTCP_CTRL_OFS); // [R3]
    assign wr_stat = reg_wr && (reg_addr == `RTCP_STAT_OFS);
    assign clr_req = {~reg_wdata[`RTCP_B_OSF], ~reg_wdata[`RTCP_B_A2F],
                      ~reg_wdata[`RTCP_B_A1F]} & {3{wr_stat}};
    assign nxt_clr_tgl = clr_tgl_ff ^ clr_req;
    assign stat_view = {flg_l2_ff[2], 3'h0, fen_ff, 1'b0,
                        flg_l2_ff[1], flg_l2_ff[0]};
    assign nxt_rdata = (reg_addr == `RTCP_CTRL_OFS) ? ctrl_ff :
                       (reg_addr == `RTCP_STAT_OFS) ? stat_view : 8'h00;
    assign nxt_mem_wr_en = mem_wr_req && !wp_s2_ff; // [R1]

    // Write-protect synchroniser, clears to low so a floating pin is open
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            wp_s1_ff <= 1'b0; // [R2]
            wp_s2_ff <= 1'b0; // [R2]
        end
        else
        begin
            wp_s1_ff <= wp_in;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    // Control and status registers, set up for an inactive interrupt
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            ctrl_ff <= `RTCP_CTRL_RST; // [R6]
            fen_ff <= `RTCP_FEN_RST;
            clr_tgl_ff <= 3'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= reg_wdata;
            if (wr_stat)
                fen_ff <= reg_wdata[`RTCP_B_FEN];
            clr_tgl_ff <= nxt_clr_tgl;
        end
    end

    // Flag view, read data and memory write gate
    always_ff @(posedge link_clk)
    begin
        flg_l1_ff <= flags_ff;
        flg_l2_ff <= flg_l1_ff;
        if (lrst)
        begin
            rdata_ff <= 8'h00;
            mem_wr_en_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            mem_wr_en_ff <= nxt_mem_wr_en;
        end
    end

    assign reg_rdata = rdata_ff;
    assign mem_wr_en = mem_wr_en_ff;

    // Core-domain state and decode
    logic [8:0] cs1_ff, cs2_ff, cs3_ff;
    logic [2:0] ct1_ff, ct2_ff, ct3_ff, ps1_ff, ps2_ff, clr_pulse, nxt_flags;
    rtcp_rst_state_t rst_st_ff, nxt_rst_st;
    logic [CW-1:0] osf_cnt_ff, rst_cnt_ff, nxt_rst_cnt, wave_cnt_ff;
    logic [CW-1:0] fix_cnt_ff, wave_half;
    logic wave_ff, fix_ff, od_low_ff, rst_oe_n_ff, irq_oe_n_ff, fix_oe_n_ff;
    logic [7:0] cs_ctrl;
    logic cs_fen, rst_pin_hi, vcc_s, run_s, osf_set, bypass, irq_act;
    logic drive_rst, wave_end, fix_end, nxt_irq_oe_n;

    // Half period of the square wave for a rate code
    function automatic logic [CW-1:0] half_sel(input logic [1:0] rs);
        logic [CW-1:0] h;
        h = CW'(HALF3);
        case (rs)
            2'd0: h = CW'(HALF0);
            2'd1: h = CW'(HALF1);
            2'd2: h = CW'(HALF2);
            default: h = CW'(HALF3);
        endcase
        return h;
    endfunction

    // Synchronisers for register bits, clear toggles and pins
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            cs1_ff <= {fen_ff, ctrl_ff};
            cs2_ff <= cs1_ff;
            // Take the word only once it is stable, so no torn update
            if (cs1_ff == cs2_ff)
                cs3_ff <= cs2_ff;
            ct1_ff <= clr_tgl_ff;
            ct2_ff <= ct1_ff;
            ct3_ff <= ct2_ff;
            ps1_ff <= {osc_run, vcc_ok, rst_in};
            ps2_ff <= ps1_ff;
        end
    end

    // Decoded core-side views
    assign cs_ctrl = cs3_ff[7:0];
    assign cs_fen = cs3_ff[8];
    assign clr_pulse = ct2_ff ^ ct3_ff;
    assign rst_pin_hi = ps2_ff[0];
    assign vcc_s = ps2_ff[1];
    assign run_s = ps2_ff[2];
    assign osf_set = !run_s && (osf_cnt_ff == CW'(OSF_CYC - 1)); // [R9]
    assign nxt_flags = {osf_set, alarm2_match, alarm1_match}
                     | (flags_ff & ~clr_pulse);
    assign bypass = cs_ctrl[`RTCP_B_ODIS] || !run_s; // [R7]
    assign irq_act = (flags_ff[0] && cs_ctrl[`RTCP_B_A1IE])
                  || (flags_ff[1] && cs_ctrl[`RTCP_B_A2IE]); // [R5]
    assign drive_rst = (nxt_rst_st == RS_DRIVE) || (nxt_rst_st == RS_HOLD);
    assign wave_half = half_sel({cs_ctrl[`RTCP_B_RSHI],
                                 cs_ctrl[`RTCP_B_RSLO]}); // [R4]
    assign wave_end = (wave_cnt_ff >= wave_half - CW'(1));
    assign fix_end = (fix_cnt_ff == CW'(FIX_HALF - 1));
    // Shared pin: wave level in wave mode, alarm in interrupt mode
    assign nxt_irq_oe_n = cs_ctrl[`RTCP_B_SEL] ? !irq_act : wave_ff; // [R3]

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (reset)
            flags_ff <= `RTCP_FLAG_RST;
        else if (ce)
            flags_ff <= nxt_flags; // [R5] [R9]
    end

    // Saturating oscillator-stop timer, cleared while the oscillator runs
    always_ff @(posedge clk)
    begin
        if (reset || (ce && run_s))
            osf_cnt_ff <= '0;
        else if (ce && !osf_set)
            osf_cnt_ff <= osf_cnt_ff + CW'(1); // [R9]
    end

    // Reset pin sequencing
    always_comb
    begin
        nxt_rst_st = rst_st_ff;
        nxt_rst_cnt = rst_cnt_ff + CW'(1);
        case (rst_st_ff)
            RS_DRIVE:
            begin
                nxt_rst_cnt = '0;
                if (vcc_s)
                    nxt_rst_st = bypass ? RS_RELEASED : RS_HOLD; // [R7]
            end
            RS_HOLD:
            begin
                if (!vcc_s)
                    nxt_rst_st = RS_DRIVE; // [R11]
                else if (bypass
                         || rst_cnt_ff == CW'(RST_CYC - 1))
                    nxt_rst_st = RS_RELEASED; // [R11] [R7]
            end
            RS_RELEASED:
            begin
                nxt_rst_cnt = '0;
                if (!vcc_s)
                    nxt_rst_st = RS_DRIVE;
                else if (!rst_pin_hi)
                    nxt_rst_st = RS_DEBOUNCE; // [R12]
            end
            RS_DEBOUNCE:
            begin
                if (!vcc_s)
                    nxt_rst_st = RS_DRIVE;
                else if (rst_pin_hi)
                    nxt_rst_st = RS_RELEASED;
                else if (rst_cnt_ff == CW'(DB_CYC - 1))
                begin
                    nxt_rst_st = RS_HOLD; // [R12]
                    nxt_rst_cnt = '0;
                end
            end
            default:
                nxt_rst_st = RS_DRIVE;
        endcase
    end

    // State and count of the reset sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rst_st_ff <= RS_DRIVE;
            rst_cnt_ff <= '0;
        end
        else if (ce)
        begin
            rst_st_ff <= nxt_rst_st;
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    // Square wave divider, keeps its count on a rate change; a count past the new half ends the phase at once
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wave_cnt_ff <= '0;
            wave_ff <= 1'b1;
        end
        else if (ce)
        begin
            wave_cnt_ff <= wave_end ? '0 : wave_cnt_ff + CW'(1);
            if (wave_end)
                wave_ff <= !wave_ff; // [R4]
        end
    end

    // Fixed clock divider, free of any supply state
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fix_cnt_ff <= '0;
            fix_ff <= 1'b1;
        end
        else if (ce)
        begin
            fix_cnt_ff <= fix_end ? '0 : fix_cnt_ff + CW'(1);
            if (fix_end)
                fix_ff <= !fix_ff; // [R10]
        end
    end

    // Open-drain pin drivers; reset pin level gates only the reset sequencer above
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            od_low_ff <= 1'b0;
            rst_oe_n_ff <= 1'b0;
            irq_oe_n_ff <= 1'b1;
            fix_oe_n_ff <= 1'b1;
        end
        else if (ce)
        begin
            od_low_ff <= 1'b0;
            rst_oe_n_ff <= !drive_rst; // [R11] [R13] [R8]
            irq_oe_n_ff <= nxt_irq_oe_n; // [R13]
            fix_oe_n_ff <= !(cs_fen && !fix_ff); // [R10] [R13]
        end
    end

    assign rst_out = od_low_ff;
    assign rst_oe_n = rst_oe_n_ff;
    assign irq_or_wave_out = od_low_ff;
    assign irq_or_wave_oe_n = irq_oe_n_ff;
    assign fixed_clock_out = od_low_ff;
    assign fixed_clock_oe_n = fix_oe_n_ff;

endmodule

// *** testbench/rtcp_top_asserts.sv ***
`timescale 1ns/10ps
module rtcp_top_asserts
    import rtcp_pkg::*;
#(
    parameter int unsigned FIX_HALF = 2
)
(
    // Clocks and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic link_clk,
    // Register and memory gate
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic mem_wr_req,
    input wire logic mem_wr_en,
    input wire logic wp_in,
    // Pins and supply
    input wire logic vcc_ok,
    input wire logic rst_out,
    input wire logic rst_oe_n,
    input wire logic irq_or_wave_out,
    input wire logic irq_or_wave_oe_n,
    input wire logic fixed_clock_out,
    input wire logic fixed_clock_oe_n
);
    logic [7:0] fc_run_ff;
    // Counts cycles of the current low phase of the fixed clock
    always_ff @(posedge clk)
    begin
        if (reset || fixed_clock_oe_n)
            fc_run_ff <= 8'h00;
        else if (ce)
            fc_run_ff <= fc_run_ff + 8'h01;
    end

    a_out_levels:
        assert property (@(posedge clk) disable iff (reset)
        !rst_out && !irq_or_wave_out && !fixed_clock_out)
        else $error("pin data not low");
    a_rst_initial:
        assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> !rst_oe_n) else $error("reset pin released early");
    a_vcc_loss:
        assert property (@(posedge clk) disable iff (reset)
        (!vcc_ok && ce) [*4] |=> !rst_oe_n) else $error("no drive on loss");
    a_rst_release:
        assert property (@(posedge clk) disable iff (reset)
        $rose(rst_oe_n) |-> $past(vcc_ok, 3)) else $error("release w/o vcc");
    a_irq_idle:
        assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> irq_or_wave_oe_n) else $error("irq not idle");
    a_fix_half:
        assert property (@(posedge clk) disable iff (reset)
        !fixed_clock_oe_n |-> fc_run_ff < FIX_HALF) else $error("low too long");
    a_rdata_unmapped:
        assert property (@(posedge link_clk) disable iff (reset)
        reg_addr != 8'h0E && reg_addr != 8'h0F |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_wp_grant:
        assert property (@(posedge link_clk) disable iff (reset)
        !wp_in [*4] ##0 mem_wr_req |=> mem_wr_en) else $error("write refused");
    a_wp_block:
        assert property (@(posedge link_clk) disable iff (reset)
        mem_wr_en |-> $past(mem_wr_req) && !$past(wp_in, 3))
        else $error("protected write granted");
endmodule

bind rtcp_top rtcp_top_asserts #(.FIX_HALF(FIX_HALF)) chk_u (.clk(clk),
    .reset(reset), .ce(ce), .link_clk(link_clk), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .mem_wr_req(mem_wr_req), .mem_wr_en(mem_wr_en),
    .wp_in(wp_in), .vcc_ok(vcc_ok), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
    .irq_or_wave_out(irq_or_wave_out), .irq_or_wave_oe_n(irq_or_wave_oe_n),
    .fixed_clock_out(fixed_clock_out), .fixed_clock_oe_n(fixed_clock_oe_n));

// *** testbench/rtcp_pin_model.sv ***
`timescale 1ns/10ps
module rtcp_pin_model
(
    // Drive-low enables from the device
    input wire logic rst_oe_n,
    input wire logic irq_oe_n,
    input wire logic fix_oe_n,
    // Pushbutton pulling the reset pin low
    input wire logic btn_press,
    // Resolved pin levels
    output logic rst_wire,
    output logic irq_wire,
    output logic fix_wire
);
    // Pulled-up wires, low while any party pulls
    assign rst_wire = rst_oe_n && !btn_press;
    assign irq_wire = irq_oe_n;
    assign fix_wire = fix_oe_n;
endmodule

// *** testbench/tb_rtc_output_pin_and_reset_control.sv ***
`timescale 1ns/10ps
`include "rtcp_map.svh"
module tb_rtc_output_pin_and_reset_control;
    localparam int RST = 20;
    localparam int DB = 20;
    localparam int OSC_STOPPED_FLAG = 10;
    localparam int FH = 3;
    localparam int HF [4] = '{8, 6, 4, 2};
    logic clk, reset, ce, link_clk, reg_wr, mem_wr_req, a1, a2, osc_run;
    logic vcc_ok, wp_in, btn, mem_wr_en, rst_out, rst_oe_n, iw_out, iw_oe_n;
    logic fc_out, fc_oe_n, rst_wire, irq_wire, fix_wire;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int num_errors = 0;
    int cmp_count = 0;
    int n;

    // Device under test with shortened counts
    rtcp_top #(.RST_CYC(RST), .DB_CYC(DB), .OSF_CYC(OSC_STOPPED_FLAG), .HALF0(HF[0]),
        .HALF1(HF[1]), .HALF2(HF[2]), .HALF3(HF[3]), .FIX_HALF(FH)) dut_u (
        .clk(clk), .reset(reset), .ce(ce), .link_clk(link_clk),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mem_wr_req(mem_wr_req),
        .mem_wr_en(mem_wr_en), .alarm1_match(a1), .alarm2_match(a2),
        .osc_run(osc_run), .vcc_ok(vcc_ok), .wp_in(wp_in),
        .rst_in(rst_wire), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
        .irq_or_wave_out(iw_out), .irq_or_wave_oe_n(iw_oe_n),
        .fixed_clock_out(fc_out), .fixed_clock_oe_n(fc_oe_n));
    // Pull-ups and pushbutton on the far side
    rtcp_pin_model pin_u (.rst_oe_n(rst_oe_n), .irq_oe_n(iw_oe_n),
        .fix_oe_n(fc_oe_n), .btn_press(btn), .rst_wire(rst_wire),
        .irq_wire(irq_wire), .fix_wire(fix_wire));

    // Core and link clocks, unrelated in phase
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    // Control byte from osc disable, rate, select and alarm enables
    function automatic logic [7:0] ctl(input logic od, input logic [1:0] rt,
        input logic sel, input logic [1:0] ie);
        return {od, 2'b00, rt, sel, ie};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge link_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge link_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge link_clk);
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge link_clk);
        reg_addr <= a;
        repeat (3) @(posedge link_clk);
        @(negedge link_clk);
        v = reg_rdata;
    endtask

    // Cycles until the reset enable reaches a level
    task automatic until_rst(input logic lvl, output int k);
        k = 0;
        while (rst_oe_n !== lvl && k < 300)
        begin
            @(negedge clk);
            k++;
        end
    endtask

    // Half period of the shared pin (0) or fixed clock pin (1)
    task automatic half(input int p, output int k);
        logic v;
        for (int i = 0; i < 2; i++)
        begin
            v = p ? fix_wire : irq_wire;
            k = 0;
            while ((p ? fix_wire : irq_wire) === v && k < 100)
            begin
                @(negedge clk);
                k++;
            end
        end
    endtask

    task automatic osc_stop(input int k);
        @(posedge clk);
        osc_run <= 1'b0;
        repeat (k) @(posedge clk);
        osc_run <= 1'b1;
        cyc(8);
    endtask

    initial
    begin
        #400000;
        num_errors++;
        close_out();
    end

    initial
    begin
        {reset, ce, osc_run, vcc_ok} = 4'hF;
        {reg_wr, mem_wr_req, a1, a2, wp_in, btn} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        d = 8'($urandom(62836));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        // Power-up hold, then idle interrupt with alarms off
        until_rst(1'b1, n);
        check(8'(n >= RST && n <= RST + 8), 8'h01);
        @(posedge clk);
        {a1, a2} <= 2'b11;
        @(posedge clk);
        {a1, a2} <= 2'b00;
        cyc(4);
        check(8'(irq_wire), 8'h01);
        rreg(8'h0E, d);
        check(d, `RTCP_CTRL_RST);
        repeat (4)
        begin
            rreg(8'($urandom_range(16, 255)), d);
            check(d, 8'h00);
        end
        // Stop flag needs the full detection interval
        wreg(8'h0F, 8'h08);
        osc_stop(OSC_STOPPED_FLAG - 2);
        rreg(8'h0F, d);
        check(d & 8'h8B, 8'h08);
        osc_stop(OSC_STOPPED_FLAG + 4);
        rreg(8'h0F, d);
        check(d & 8'h8B, 8'h88);
        // Each alarm reaches the pin only when enabled
        for (int i = 0; i < 4; i++)
        begin
            wreg(8'h0E, ctl(1'b0, 2'b00, 1'b1, i < 2 ? 2'b01 : 2'b10));
            wreg(8'h0F, 8'h08);
            cyc(8);
            @(posedge clk);
            a1 <= (i == 0 || i == 3);
            a2 <= (i == 1 || i == 2);
            @(posedge clk);
            {a1, a2} <= 2'b00;
            cyc(3);
            check(8'(irq_wire), 8'(i % 2));
        end
        // Square wave rates
        for (int r = 0; r < 4; r++)
        begin
            wreg(8'h0E, ctl(1'b0, 2'(r), 1'b0, 2'b00));
            cyc(6);
            half(0, n);
            check(8'(n), 8'(HF[r]));
        end
        wreg(8'h0E, ctl(1'b0, 2'b00, 1'b1, 2'b00));
        // Supply loss: pin low, fixed clock keeps running
        @(posedge clk);
        vcc_ok <= 1'b0;
        cyc(6);
        check(8'(rst_wire), 8'h00);
        half(1, n);
        check(8'(n), 8'(FH));
        wreg(8'h0F, 8'h00);
        cyc(3 * FH + 4);
        check(8'(fix_wire), 8'h01);
        @(posedge clk);
        vcc_ok <= 1'b1;
        until_rst(1'b1, n);
        check(8'(n >= RST), 8'h01);
        // Oscillator disabled: recovery bypassed
        wreg(8'h0E, ctl(1'b1, 2'b00, 1'b1, 2'b00));
        @(posedge clk);
        vcc_ok <= 1'b0;
        cyc(6);
        vcc_ok <= 1'b1;
        until_rst(1'b1, n);
        check(8'(n <= 6), 8'h01);
        wreg(8'h0E, ctl(1'b0, 2'b00, 1'b1, 2'b00));
        // Short press ignored, long press starts a reset
        @(posedge clk);
        btn <= 1'b1;
        cyc(5);
        btn <= 1'b0;
        cyc(DB + 6);
        check(8'(rst_oe_n), 8'h01);
        btn <= 1'b1;
        until_rst(1'b0, n);
        check(8'(n >= DB && n <= DB + 8), 8'h01);
        btn <= 1'b0;
        wreg(8'h0E, 8'h07);
        rreg(8'h0E, d);
        check(d, 8'h07);
        check(8'(rst_oe_n), 8'h00);
        until_rst(1'b1, n);
        // Write protect gates memory grants
        @(posedge link_clk);
        mem_wr_req <= 1'b1;
        repeat (4) @(posedge link_clk);
        check(8'(mem_wr_en), 8'h01);
        wp_in <= 1'b1;
        repeat (4) @(posedge link_clk);
        check(8'(mem_wr_en), 8'h00);
        repeat (80)
        begin
            @(posedge link_clk);
            mem_wr_req <= 1'($urandom);
            if ($urandom_range(0, 7) == 0)
                wp_in <= ~wp_in;
        end
        close_out();
    end
endmodule
